// *** hdl/rfa_defines.svh ***
// Constants for the radio queue access and status block.
`ifndef RFA_DEFINES_SVH
`define RFA_DEFINES_SVH

`define RFA_ADDR_DATA_PORT 8'hD9
`define RFA_ADDR_IRQ_FLAGS 8'hE9
`define RFA_BIT_THR_IRQ 5
`define RFA_BIT_SFD_IRQ 4
`define RFA_QUEUE_DEPTH 128
`define RFA_THR_WIDTH 7
`define RFA_LEN_MSB 6
`define RFA_DMA_TRIGGER_ID 19
`define RFA_CORR_THR_STANDARD 20
`define RFA_BYTE_ZERO 8'h00
`define RFA_BUF_EMPTY 2'h0
`define RFA_BUF_ONE 2'h1
`define RFA_BUF_FULL 2'h2
`define RFA_LEN_ZERO 7'h00
`define RFA_LEN_ONE 7'h01

`endif

// *** hdl/rfa_pkg.sv ***
// Types shared by the radio queue access and status block.
package rfa_pkg;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LENGTH = 2'b01,
    TX_PAYLOAD = 2'b10
  } rfa_tx_state_type;

  typedef enum logic [1:0] {
    DBG_CCA = 2'b00,
    DBG_THRESHOLD = 2'b01,
    DBG_NOT_EMPTY = 2'b10,
    DBG_FRAME_START = 2'b11
  } rfa_debug_src_type;

endpackage

// *** hdl/rfa_queue_mem.sv ***
// Byte queue storage with pointers, count and a registered head byte.
`timescale 1ns/10ps
`default_nettype none
`include "rfa_defines.svh"

module rfa_queue_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `RFA_QUEUE_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_ref_clk, // System clock.
  input wire logic i_sys_rst, // Synchronous reset, active high.
  input wire logic i_push, // Store one byte at the tail.
  input wire logic [WIDTH-1:0] i_push_data, // Byte to store.
  input wire logic i_pop, // Drop the head byte.
  input wire logic i_flush, // Empty the queue.
  output logic [AW:0] o_count, // Bytes held.
  output logic [WIDTH-1:0] o_head, // Head byte, registered.
  output logic o_head_ok, // Head byte is current.
  output logic o_full // No room left.
);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic do_push;
  logic do_pop;

  assign o_full = (o_count == (AW+1)'(DEPTH));
  assign do_push = i_push && !o_full && !i_flush;
  assign do_pop = i_pop && (o_count != '0) && !i_flush;

  always_ff @(posedge i_ref_clk) begin
    if (do_push) begin
      mem[wr_ptr] <= i_push_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (do_pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      o_count <= (AW+1)'(o_count + do_push - do_pop);
    end
  end

  // The head register lags a pointer move or a first write by one cycle.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_head <= '0;
      o_head_ok <= 1'b0;
    end else begin
      o_head <= mem[rd_ptr];
      o_head_ok <= !i_flush && (o_count != '0) && !do_pop;
    end
  end

endmodule
`default_nettype wire

// *** hdl/rfa_radio_queue.sv ***
// Radio data port, transmit and receive queues, status bits and flags.
`timescale 1ns/10ps
`default_nettype none
`include "rfa_defines.svh"

module rfa_radio_queue #(
  parameter int DEPTH = `RFA_QUEUE_DEPTH,
  parameter int THR_W = `RFA_THR_WIDTH
) (
  input wire logic i_ref_clk, // System clock, 50 MHz.
  input wire logic i_sys_rst, // Synchronous reset, active high.
  input wire logic [7:0] i_sfr_addr, // Special-function register address.
  input wire logic i_sfr_wr, // Register write strobe.
  input wire logic i_sfr_rd, // Register read strobe.
  input wire logic [7:0] i_sfr_wdata, // Register write data.
  output logic [7:0] o_sfr_rdata, // Register read data, one cycle after the strobe.
  input wire logic i_transmit_flush_strobe, // Empty the transmit queue.
  input wire logic i_receive_flush_strobe, // Empty the receive queue.
  input wire logic i_rx_byte_valid, // Demodulator offers a byte.
  input wire logic [7:0] i_rx_byte, // Received byte.
  input wire logic i_rx_frame_last, // Offered byte is the frame's last.
  input wire logic i_rx_sfd_done, // Delimiter fully received.
  input wire logic i_addr_filter_en, // Address filtering enabled.
  input wire logic i_addr_pass, // Current frame passed filtering.
  input wire logic i_addr_fail, // Current frame failed filtering.
  input wire logic [THR_W-1:0] i_rx_threshold_field, // Threshold for the threshold bit.
  input wire logic i_tx_sfd_done, // Delimiter fully sent.
  output logic o_tx_byte_valid, // Byte offered to the modulator.
  output logic [7:0] o_tx_byte, // Byte for the modulator.
  input wire logic i_tx_byte_ready, // Modulator takes the byte.
  input wire logic i_channel_clear_bit, // Channel clear indication.
  input wire logic i_error_irq_enable, // Enables the error interrupt.
  input wire logic [7:0] i_debug_select, // Two select bits per debug pin.
  input wire logic [3:0] i_debug_invert, // Polarity per debug pin.
  output logic o_radio_irq_req, // Radio interrupt request pulse.
  output logic o_radio_error_interrupt, // Error interrupt pulse.
  output logic o_dma_trigger, // Radio DMA trigger pulse.
  output logic [7:0] o_rx_byte_count, // Bytes in the receive queue.
  output logic o_frame_start_status_bit, // Frame in progress.
  output logic o_rx_not_empty_bit, // Receive queue holds data.
  output logic o_rx_threshold_bit, // Receive threshold reached.
  output logic [3:0] o_debug_pins, // Routed status bits.
  output logic o_tx_queue_full // Transmit queue full.
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------

  // Picks one status bit for a debug pin.
  function automatic logic rfa_pick(input logic [1:0] sel, input logic [3:0] stat);
    rfa_pkg::rfa_debug_src_type src;
    src = rfa_pkg::rfa_debug_src_type'(sel);
    unique case (src)
      rfa_pkg::DBG_CCA: rfa_pick = stat[0];
      rfa_pkg::DBG_THRESHOLD: rfa_pick = stat[1];
      rfa_pkg::DBG_NOT_EMPTY: rfa_pick = stat[2];
      rfa_pkg::DBG_FRAME_START: rfa_pick = stat[3];
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------

  logic port_wr;
  logic port_rd;
  logic flags_wr;

  assign port_wr = i_sfr_wr && (i_sfr_addr == `RFA_ADDR_DATA_PORT);
  assign port_rd = i_sfr_rd && (i_sfr_addr == `RFA_ADDR_DATA_PORT);
  assign flags_wr = i_sfr_wr && (i_sfr_addr == `RFA_ADDR_IRQ_FLAGS);

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------

  logic [AW:0] rx_count;
  logic [7:0] rx_head;
  logic rx_head_ok;
  logic rx_full;
  logic rx_overflow;
  logic rx_push;
  logic rx_pop;
  logic rx_overflow_event;
  logic rx_last_push;

  // Bytes are refused while the overflow lock stands.
  assign rx_push = i_rx_byte_valid && !rx_overflow && !rx_full;
  assign rx_overflow_event = i_rx_byte_valid && !rx_overflow && rx_full;
  assign rx_pop = port_rd && (rx_count != '0);
  assign rx_last_push = rx_push && i_rx_frame_last;

  rfa_queue_mem #(
    .WIDTH(8),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_rx_queue (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_push(rx_push),
    .i_push_data(i_rx_byte),
    .i_pop(rx_pop),
    .i_flush(i_receive_flush_strobe),
    .o_count(rx_count),
    .o_head(rx_head),
    .o_head_ok(rx_head_ok),
    .o_full(rx_full)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_receive_flush_strobe) begin
      rx_overflow <= 1'b0;
    end else if (rx_overflow_event) begin
      rx_overflow <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Transmit queue and two-entry output buffer
  // ----------------------------------------------------------------

  logic [AW:0] tx_count;
  logic [7:0] tx_head;
  logic tx_head_ok;
  logic tx_full;
  logic tx_pop;
  logic [7:0] buf_first;
  logic [7:0] buf_second;
  logic [1:0] buf_cnt;
  logic buf_in_ready;
  logic out_fire;

  assign buf_in_ready = (buf_cnt != `RFA_BUF_FULL);
  assign tx_pop = tx_head_ok && buf_in_ready && !i_transmit_flush_strobe;
  assign o_tx_byte_valid = (buf_cnt != `RFA_BUF_EMPTY);
  assign o_tx_byte = buf_first;
  assign out_fire = o_tx_byte_valid && i_tx_byte_ready;
  assign o_tx_queue_full = tx_full;

  // A full queue ignores the push inside the storage module.
  rfa_queue_mem #(
    .WIDTH(8),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_tx_queue (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_push(port_wr),
    .i_push_data(i_sfr_wdata),
    .i_pop(tx_pop),
    .i_flush(i_transmit_flush_strobe),
    .o_count(tx_count),
    .o_head(tx_head),
    .o_head_ok(tx_head_ok),
    .o_full(tx_full)
  );

  // The buffer absorbs a modulator stall without losing a fetched byte.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_transmit_flush_strobe) begin
      buf_cnt <= `RFA_BUF_EMPTY;
      buf_first <= `RFA_BYTE_ZERO;
      buf_second <= `RFA_BYTE_ZERO;
    end else begin
      unique case ({tx_pop, out_fire})
        2'b10: begin
          if (buf_cnt == `RFA_BUF_EMPTY) begin
            buf_first <= tx_head;
          end else begin
            buf_second <= tx_head;
          end
          buf_cnt <= 2'(buf_cnt + 1'b1);
        end
        2'b01: begin
          buf_first <= buf_second;
          buf_cnt <= 2'(buf_cnt - 1'b1);
        end
        2'b11: begin
          if (buf_cnt == `RFA_BUF_ONE) begin
            buf_first <= tx_head;
          end else begin
            buf_first <= buf_second;
            buf_second <= tx_head;
          end
        end
        2'b00: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit frame tracking
  // ----------------------------------------------------------------

  rfa_pkg::rfa_tx_state_type tx_state;
  logic [`RFA_LEN_MSB:0] tx_remaining;
  logic tx_end;
  logic tx_underflow;

  assign tx_end = out_fire && (((tx_state == rfa_pkg::TX_LENGTH) &&
    (o_tx_byte[`RFA_LEN_MSB:0] == `RFA_LEN_ZERO)) ||
    ((tx_state == rfa_pkg::TX_PAYLOAD) && (tx_remaining == `RFA_LEN_ONE)));
  assign tx_underflow = (tx_state != rfa_pkg::TX_IDLE) && i_tx_byte_ready &&
    !o_tx_byte_valid && (tx_count == '0);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tx_state <= rfa_pkg::TX_IDLE;
      tx_remaining <= `RFA_LEN_ZERO;
    end else if (i_tx_sfd_done) begin
      tx_state <= rfa_pkg::TX_LENGTH;
    end else if (tx_end || tx_underflow) begin
      tx_state <= rfa_pkg::TX_IDLE;
    end else if (out_fire && (tx_state == rfa_pkg::TX_LENGTH)) begin
      tx_remaining <= o_tx_byte[`RFA_LEN_MSB:0];
      tx_state <= rfa_pkg::TX_PAYLOAD;
    end else if (out_fire && (tx_state == rfa_pkg::TX_PAYLOAD)) begin
      tx_remaining <= (`RFA_LEN_MSB+1)'(tx_remaining - 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Frame-start status and receive frame tracking
  // ----------------------------------------------------------------

  logic rx_in_frame;
  logic addr_passed;
  logic fs_clear;

  // A flush during overflow only lifts the lock, so a second is needed.
  assign fs_clear = rx_last_push || i_addr_fail || tx_end || tx_underflow ||
    (i_receive_flush_strobe && !rx_overflow);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_frame_start_status_bit <= 1'b0;
    end else if (i_rx_sfd_done || i_tx_sfd_done) begin
      o_frame_start_status_bit <= 1'b1;
    end else if (fs_clear) begin
      o_frame_start_status_bit <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rx_in_frame <= 1'b0;
    end else if (i_rx_sfd_done) begin
      rx_in_frame <= 1'b1;
    end else if (rx_last_push || i_addr_fail || i_receive_flush_strobe || rx_overflow_event) begin
      rx_in_frame <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_rx_sfd_done) begin
      addr_passed <= 1'b0;
    end else if (i_addr_pass) begin
      addr_passed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Receive status bits
  // ----------------------------------------------------------------

  logic rx_last_flag;
  logic thr_gate;
  logic next_rx_threshold_bit;
  logic next_rx_not_empty_bit;

  // The final byte of a frame holds the threshold bit up until one read.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_receive_flush_strobe) begin
      rx_last_flag <= 1'b0;
    end else if (rx_last_push) begin
      rx_last_flag <= 1'b1;
    end else if (rx_pop) begin
      rx_last_flag <= 1'b0;
    end
  end

  assign thr_gate = i_addr_filter_en && rx_in_frame && !addr_passed;
  assign next_rx_threshold_bit = rx_overflow ||
    rx_last_flag ||
    (!thr_gate && (rx_count > (AW+1)'(i_rx_threshold_field)));
  assign next_rx_not_empty_bit = !rx_overflow && (rx_count != '0);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rx_threshold_bit <= 1'b0;
      o_rx_not_empty_bit <= 1'b0;
      o_rx_byte_count <= `RFA_BYTE_ZERO;
    end else begin
      o_rx_threshold_bit <= next_rx_threshold_bit;
      o_rx_not_empty_bit <= next_rx_not_empty_bit;
      o_rx_byte_count <= 8'(rx_count);
    end
  end

  // ----------------------------------------------------------------
  // DMA trigger, interrupt flags and requests
  // ----------------------------------------------------------------

  logic irq_sfd_flag;
  logic irq_thr_flag;
  logic thr_rise;

  assign thr_rise = next_rx_threshold_bit && !o_rx_threshold_bit;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst || i_receive_flush_strobe) begin
      o_dma_trigger <= 1'b0;
    end else begin
      o_dma_trigger <= (rx_push && (rx_count == '0)) ||
        (rx_pop && (rx_count > (AW+1)'(1)));
    end
  end

  // Written zero clears a flag, written one keeps it, and a new event wins.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      irq_sfd_flag <= 1'b0;
      irq_thr_flag <= 1'b0;
    end else begin
      irq_sfd_flag <= i_rx_sfd_done || i_tx_sfd_done ||
        (irq_sfd_flag && !(flags_wr && !i_sfr_wdata[`RFA_BIT_SFD_IRQ]));
      irq_thr_flag <= thr_rise ||
        (irq_thr_flag && !(flags_wr && !i_sfr_wdata[`RFA_BIT_THR_IRQ]));
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_radio_irq_req <= 1'b0;
      o_radio_error_interrupt <= 1'b0;
    end else begin
      o_radio_irq_req <= i_rx_sfd_done || i_tx_sfd_done || thr_rise;
      o_radio_error_interrupt <= i_error_irq_enable &&
        (rx_overflow_event || tx_underflow);
    end
  end

  // ----------------------------------------------------------------
  // Register read data
  // ----------------------------------------------------------------

  logic [7:0] flags_view;

  always_comb begin
    flags_view = `RFA_BYTE_ZERO;
    flags_view[`RFA_BIT_SFD_IRQ] = irq_sfd_flag;
    flags_view[`RFA_BIT_THR_IRQ] = irq_thr_flag;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_sfr_rdata <= `RFA_BYTE_ZERO;
    end else if (port_rd) begin
      o_sfr_rdata <= (rx_count != '0) ? rx_head : `RFA_BYTE_ZERO;
    end else if (i_sfr_rd && (i_sfr_addr == `RFA_ADDR_IRQ_FLAGS)) begin
      o_sfr_rdata <= flags_view;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= `RFA_BYTE_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Debug pin routing
  // ----------------------------------------------------------------

  logic [3:0] dbg_status;

  assign dbg_status = {o_frame_start_status_bit, o_rx_not_empty_bit,
    o_rx_threshold_bit, i_channel_clear_bit};

  for (genvar p = 0; p < 4; p++) begin : g_debug
    always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
        o_debug_pins[p] <= 1'b0;
      end else begin
        o_debug_pins[p] <= rfa_pick(i_debug_select[2*p+1:2*p], dbg_status) ^
          i_debug_invert[p];
      end
    end
  end

endmodule
`default_nettype wire

// *** testbench/rfa_radio_queue_monitor.sv ***
// Port checker for the radio queue access and status block.
`timescale 1ns/10ps
`default_nettype none
module rfa_radio_queue_monitor #(
  parameter int THR_W = 7
) (
  input wire logic i_ref_clk, // Clock.
  input wire logic i_sys_rst, // Reset.
  input wire logic [7:0] i_sfr_addr, // Address.
  input wire logic i_sfr_rd, // Read strobe.
  input wire logic i_receive_flush_strobe, // Rx flush.
  input wire logic i_rx_byte_valid, // Rx byte.
  input wire logic i_rx_frame_last, // Last byte.
  input wire logic i_rx_sfd_done, // Rx delimiter.
  input wire logic i_tx_sfd_done, // Tx delimiter.
  input wire logic i_addr_filter_en, // Filter on.
  input wire logic i_addr_fail, // Filter fail.
  input wire logic [THR_W-1:0] i_rx_threshold_field, // Threshold.
  input wire logic i_error_irq_enable, // Error enable.
  input wire logic [7:0] o_sfr_rdata, // Read data.
  input wire logic o_radio_irq_req, // Irq.
  input wire logic o_radio_error_interrupt, // Error.
  input wire logic o_dma_trigger, // Dma.
  input wire logic [7:0] o_rx_byte_count, // Count.
  input wire logic o_frame_start_status_bit, // Frame.
  input wire logic o_rx_not_empty_bit, // Not empty.
  input wire logic o_rx_threshold_bit // Threshold.
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence s_ovf_byte;
    i_rx_byte_valid && o_rx_byte_count == 8'h80 && o_rx_not_empty_bit && i_error_irq_enable;
  endsequence
  sequence s_locked;
    !o_rx_not_empty_bit && o_rx_threshold_bit;
  endsequence
  a_sfd_irq: assert property ((i_rx_sfd_done || i_tx_sfd_done) |=>
    o_radio_irq_req && o_frame_start_status_bit) else $error("no irq after delimiter");
  a_dma_first: assert property ($rose(o_rx_not_empty_bit) |-> $past(o_dma_trigger))
    else $error("no dma on first byte");
  a_dma_read: assert property (i_sfr_rd && i_sfr_addr == 8'hD9 && o_rx_byte_count > 8'h01 &&
    !i_receive_flush_strobe |=> o_dma_trigger) else $error("no dma on read");
  a_last_ends: assert property (i_rx_byte_valid && i_rx_frame_last |=>
    !o_frame_start_status_bit) else $error("frame start after last byte");
  a_fail_ends: assert property (i_addr_fail |=> !o_frame_start_status_bit)
    else $error("frame start after filter fail");
  a_thr_count: assert property (!i_addr_filter_en && $stable(i_addr_filter_en) &&
    $stable(i_rx_threshold_field) && o_rx_byte_count > 8'(i_rx_threshold_field)
    |-> o_rx_threshold_bit) else $error("threshold low above field");
  a_ovf_signal: assert property (s_ovf_byte |=> o_radio_error_interrupt ##1 s_locked)
    else $error("overflow not signalled");
  a_lock_holds: assert property (s_locked and (o_rx_byte_count != 8'h00 &&
    !i_receive_flush_strobe && !$past(i_receive_flush_strobe)) |=> s_locked)
    else $error("overflow lock lost");
  a_flush_clears: assert property (i_receive_flush_strobe && !i_rx_byte_valid |->
    ##2 o_rx_byte_count == 8'h00 && !o_rx_not_empty_bit) else $error("flush left data");
  a_flag_bits: assert property (i_sfr_rd && i_sfr_addr != 8'hD9 |=>
    (o_sfr_rdata & 8'hCF) == 8'h00) else $error("stray read bits");
  a_empty_read: assert property (i_sfr_rd && i_sfr_addr == 8'hD9 && o_rx_byte_count == 8'h00 &&
    !o_rx_not_empty_bit && !i_rx_byte_valid && !$past(i_rx_byte_valid) |=> o_sfr_rdata == 8'h00)
    else $error("empty read not zero");
endmodule
bind rfa_radio_queue rfa_radio_queue_monitor #(.THR_W(THR_W)) u_rfa_radio_queue_monitor (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_rd(i_sfr_rd),
  .i_receive_flush_strobe(i_receive_flush_strobe), .i_rx_byte_valid(i_rx_byte_valid),
  .i_rx_frame_last(i_rx_frame_last), .i_rx_sfd_done(i_rx_sfd_done),
  .i_tx_sfd_done(i_tx_sfd_done), .i_addr_filter_en(i_addr_filter_en),
  .i_addr_fail(i_addr_fail), .i_rx_threshold_field(i_rx_threshold_field),
  .i_error_irq_enable(i_error_irq_enable), .o_sfr_rdata(o_sfr_rdata),
  .o_radio_irq_req(o_radio_irq_req), .o_radio_error_interrupt(o_radio_error_interrupt),
  .o_dma_trigger(o_dma_trigger), .o_rx_byte_count(o_rx_byte_count),
  .o_frame_start_status_bit(o_frame_start_status_bit),
  .o_rx_not_empty_bit(o_rx_not_empty_bit), .o_rx_threshold_bit(o_rx_threshold_bit));
`default_nettype wire

// *** testbench/rfa_tx_sink.sv ***
// Modulator model that takes transmit bytes with periodic stalls.
`timescale 1ns/10ps
`default_nettype none
module rfa_tx_sink (
  input wire logic i_ref_clk, // Clock.
  input wire logic i_sys_rst, // Reset.
  input wire logic i_run, // Frame in progress.
  input wire logic i_valid, // Byte offered.
  input wire logic [7:0] i_byte, // Offered byte.
  output logic o_ready // Takes the byte.
);
  logic [1:0] phase;
  logic [7:0] got [$];
  always @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      phase <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      // Every fourth cycle stalls, so the output buffer must hold its word.
      o_ready <= i_run && phase != 2'h3;
      if (i_valid && o_ready) begin
        got.push_back(i_byte);
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/rfa_radio_queue_tb.sv ***
// Self-checking bench for the radio queue access and status block.
`timescale 1ns/10ps
`default_nettype none
module rfa_radio_queue_tb;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rxb = 8'h00;
  logic [6:0] thr = 7'h07;
  logic [5:0] ctl = 6'h00;
  logic wr = 1'b0, rd = 1'b0, rxv = 1'b0, rxl = 1'b0, filt = 1'b0, cca = 1'b0, run = 1'b0;
  logic txv, txr, full, irq, err, dma, sfd, nemp, thb;
  logic [7:0] txb, rdata, cnt, d;
  logic [3:0] dbg;
  int miscompares = 0;
  int comparisons = 0;
  int dma_n = 0, err_n = 0, irq_n = 0;
  rfa_radio_queue u_rfa_radio_queue (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_transmit_flush_strobe(ctl[5]), .i_receive_flush_strobe(ctl[4]), .i_rx_byte_valid(rxv),
    .i_rx_byte(rxb), .i_rx_frame_last(rxl), .i_rx_sfd_done(ctl[0]), .i_addr_filter_en(filt),
    .i_addr_pass(ctl[2]), .i_addr_fail(ctl[3]), .i_rx_threshold_field(thr),
    .i_tx_sfd_done(ctl[1]), .o_tx_byte_valid(txv), .o_tx_byte(txb), .i_tx_byte_ready(txr),
    .i_channel_clear_bit(cca), .i_error_irq_enable(1'b1), .i_debug_select(8'hE4),
    .i_debug_invert(4'h1), .o_radio_irq_req(irq), .o_radio_error_interrupt(err),
    .o_dma_trigger(dma), .o_rx_byte_count(cnt), .o_frame_start_status_bit(sfd),
    .o_rx_not_empty_bit(nemp), .o_rx_threshold_bit(thb), .o_debug_pins(dbg),
    .o_tx_queue_full(full));
  rfa_tx_sink u_rfa_tx_sink (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_run(run),
    .i_valid(txv), .i_byte(txb), .o_ready(txr));
  initial forever #10 i_ref_clk = ~i_ref_clk;
  // ----------------------------------------------------------------
  // Pulse counters and bus helpers.
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (dma === 1'b1) dma_n <= dma_n + 1;
    if (err === 1'b1) err_n <= err_n + 1;
    if (irq === 1'b1) irq_n <= irq_n + 1;
  end
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task pulse(input int k);
    @(posedge i_ref_clk) ctl[k] <= 1'b1;
    @(posedge i_ref_clk) ctl[k] <= 1'b0;
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_ref_clk) {wr, addr, wdata} <= {1'b1, a, v};
    @(posedge i_ref_clk) wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge i_ref_clk) {rd, addr} <= {1'b1, a};
    @(posedge i_ref_clk) rd <= 1'b0;
    #1 d = rdata;
    @(posedge i_ref_clk);
  endtask
  task rx_byte(input logic [7:0] b, input logic l);
    @(posedge i_ref_clk) {rxv, rxb, rxl} <= {1'b1, b, l};
    @(posedge i_ref_clk) {rxv, rxl} <= 2'b00;
  endtask
  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task t_idle;
    rd_reg(8'hE9);
    chk("flags", d, 8'h00);
    rd_reg(8'hD9);
    chk("empty_read", d, 8'h00);
    rd_reg(8'h55);
    chk("unmapped", d, 8'h00);
    chk("count", cnt, 8'h00);
    chk("tx_full", {7'h00, full}, 8'h00);
    chk("debug", {4'h0, dbg}, 8'h01);
    @(posedge i_ref_clk) cca <= 1'b1;
    tick(3);
    chk("debug_cca", {4'h0, dbg}, 8'h00);
  endtask
  task t_tx;
    logic [7:0] e [3];
    e = '{8'h02, 8'hA5, 8'h5A};
    foreach (e[i]) wr_reg(8'hD9, e[i]);
    pulse(1);
    tick(1);
    chk("tx_frame", {7'h00, sfd}, 8'h01);
    chk("irq_count", 8'(irq_n), 8'h01);
    @(posedge i_ref_clk) run <= 1'b1;
    for (int i = 0; i < 200 && u_rfa_tx_sink.got.size() < 3; i++) tick(1);
    tick(3);
    chk("tx_end", {7'h00, sfd}, 8'h00);
    foreach (e[i]) chk("tx_byte", u_rfa_tx_sink.got[i], e[i]);
    @(posedge i_ref_clk) run <= 1'b0;
    wr_reg(8'hD9, 8'h01);
    pulse(1);
    @(posedge i_ref_clk) run <= 1'b1;
    tick(30);
    chk("underflow", {7'h00, sfd}, 8'h00);
    chk("underflow_err", 8'(err_n), 8'h01);
    @(posedge i_ref_clk) run <= 1'b0;
    wr_reg(8'hD9, 8'h33);
    wr_reg(8'hD9, 8'h44);
    tick(4);
    chk("tx_held", {7'h00, txv}, 8'h01);
    pulse(5);
    tick(3);
    chk("tx_flushed", {7'h00, txv}, 8'h00);
  endtask
  task t_rx;
    logic [7:0] e [4];
    e = '{8'h03, 8'h11, 8'h22, 8'h33};
    pulse(0);
    tick(1);
    chk("rx_frame", {7'h00, sfd}, 8'h01);
    foreach (e[i]) rx_byte(e[i], i == 3);
    tick(3);
    chk("rx_end", {7'h00, sfd}, 8'h00);
    chk("count", cnt, 8'h04);
    chk("not_empty", {7'h00, nemp}, 8'h01);
    chk("frame_thr", {7'h00, thb}, 8'h01);
    chk("dma_fill", 8'(dma_n), 8'h01);
    rd_reg(8'hE9);
    chk("flags_set", d, 8'h30);
    wr_reg(8'hE9, 8'h00);
    rd_reg(8'hE9);
    chk("flags_clr", d, 8'h00);
    foreach (e[i]) begin
      rd_reg(8'hD9);
      chk("rx_byte", d, e[i]);
      tick(2);
      if (i == 0) chk("thr_after_read", {7'h00, thb}, 8'h00);
    end
    chk("drained", {7'h00, nemp}, 8'h00);
    chk("dma_read", 8'(dma_n), 8'h04);
  endtask
  task t_filter;
    @(posedge i_ref_clk) {filt, thr} <= {1'b1, 7'h00};
    pulse(0);
    rx_byte(8'h02, 1'b0);
    rx_byte(8'hAA, 1'b0);
    tick(3);
    chk("filt_count", cnt, 8'h02);
    chk("filt_thr", {7'h00, thb}, 8'h00);
    pulse(2);
    tick(3);
    chk("pass_thr", {7'h00, thb}, 8'h01);
    rx_byte(8'hBB, 1'b1);
    pulse(4);
    tick(3);
    chk("flushed", cnt, 8'h00);
    pulse(0);
    rx_byte(8'h01, 1'b0);
    pulse(3);
    tick(1);
    chk("fail_frame", {7'h00, sfd}, 8'h00);
    pulse(4);
    tick(3);
    @(posedge i_ref_clk) {filt, thr} <= {1'b0, 7'h07};
  endtask
  task t_overflow;
    pulse(0);
    for (int i = 0; i < 128; i++) rx_byte(8'(i) ^ 8'hA5, 1'b0);
    tick(3);
    chk("full_count", cnt, 8'h80);
    rx_byte(8'h5C, 1'b0);
    tick(3);
    chk("ovf_err", 8'(err_n), 8'h02);
    chk("ovf_not_empty", {7'h00, nemp}, 8'h00);
    chk("ovf_thr", {7'h00, thb}, 8'h01);
    rd_reg(8'hD9);
    chk("ovf_read", d, 8'hA5);
    rx_byte(8'h77, 1'b0);
    tick(3);
    chk("ovf_refuse", cnt, 8'h7F);
    pulse(4);
    pulse(4);
    tick(3);
    chk("ovf_flushed", cnt, 8'h00);
    chk("ovf_idle", {7'h00, sfd}, 8'h00);
  endtask
  task stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    tick(2);
    t_idle();
    t_tx();
    t_rx();
    t_filter();
    t_overflow();
    stop_test();
  end
endmodule
`default_nettype wire
